// *** design/atrf_pkg.sv ***
/*
  package for the conversion trigger and result format block: register
  offsets, field positions, reset values and trigger codes.
  assumes nothing beyond a SystemVerilog compiler.
*/
package atrf_pkg;

  // register offsets on the plain register port
  localparam logic [1:0] OFF_TRIG_CTRL = 2'h0;
  localparam logic [1:0] OFF_RES_HIGH = 2'h1;
  localparam logic [1:0] OFF_RES_LOW = 2'h2;
  localparam logic [1:0] OFF_FORMAT = 2'h3;

  // field positions
  localparam int TRIG_SEL_LSB = 4;
  localparam int TRIG_SEL_MSB = 6;
  localparam int JUSTIFY_BIT = 7;

  // reset values
  localparam logic [2:0] TRIG_SEL_RESET = 3'h0;
  localparam logic JUSTIFY_RESET = 1'b0;

  // trigger source codes
  typedef enum logic [2:0] {
    TRIG_NONE = 3'b000,
    TRIG_RSV1 = 3'b001,
    TRIG_RSV2 = 3'b010,
    TRIG_TIMER_ZERO = 3'b011,
    TRIG_TIMER_ONE = 3'b100,
    TRIG_TIMER_TWO = 3'b101,
    TRIG_CMP_ONE = 3'b110,
    TRIG_CMP_TWO = 3'b111
  } atrf_trig_type;

endpackage

// *** design/atrf_src_if.sv ***
/*
  interface carrying the trigger sources and the selected code between
  the top and the trigger selector.
  assumes all signals are on clk_i.
*/
`timescale 1ns/1ns
interface atrf_src_if;
  logic [4:0] src;
  atrf_pkg::atrf_trig_type sel;
  logic start;
  modport top (output src, output sel, input start);
  modport sel_side (input src, input sel, output start);
endinterface

// *** design/atrf_top.sv ***
/*
  conversion trigger control and result formatting block.
  assumes a plain register port on clk_i, a converter core giving a
  10-bit result with a one-cycle valid strobe, and timer events as
  one-cycle pulses on clk_i; comparator outputs arrive from pins.
*/
// The address map and strobed register access were left to the implementer.
// Behaviour
// - conversion starts only on a rising edge of the chosen source
// - timer events used as triggers still set their own flags
// - control bit 7 and bits 3:0 read as zero
// - left format: high byte holds result bits 9:2
// - left format: low byte bits 7:6 hold result bits 1:0
// - right format: high byte bits 1:0 hold result bits 9:8
// - right format: low byte holds result bits 7:0
// - trigger field resets to zero; result bytes keep value, are r/w
`timescale 1ns/1ns
module atrf_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // trigger sources
  input wire logic timer_zero_ovf_i,
  input wire logic timer_one_ovf_i,
  input wire logic timer_two_period_i,
  input wire logic comparator_one_synced_out_i,
  input wire logic comparator_two_synced_out_i,
  // timer interrupt flags, the timer events registered one cycle later
  output logic timer_zero_flag_o,
  output logic timer_one_flag_o,
  output logic timer_two_flag_o,
  // converter core
  input wire logic [9:0] conversion_result_i,
  input wire logic result_valid_i,
  output logic start_conv_o
);

  atrf_src_if sif ();

  logic [2:0] trig_q;
  logic [2:0] trig_d;
  logic just_q;
  logic just_d;
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic [7:0] lo_q;
  logic [7:0] lo_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [2:0] flag_q;
  logic [2:0] flag_d;
  logic start_q;
  logic [1:0] c1_sync_q;
  logic [1:0] c2_sync_q;

  // packs the result per justify bit; unused bits are left zero
  function automatic logic [15:0] pack(input logic j, input logic [9:0] r);
    logic [15:0] v;
    v = 16'h0000;
    if (j)
    begin
      v[9:0] = r;
    end
    else
    begin
      v[15:6] = r;
    end
    return v;
  endfunction

  // comparators come from pins: two flops before use
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      c1_sync_q <= 2'h0;
      c2_sync_q <= 2'h0;
    end
    else
    begin
      c1_sync_q <= {c1_sync_q[0], comparator_one_synced_out_i};
      c2_sync_q <= {c2_sync_q[0], comparator_two_synced_out_i};
    end
  end

  // source bundle to the selector
  assign sif.src = {c2_sync_q[1], c1_sync_q[1], timer_two_period_i,
                    timer_one_ovf_i, timer_zero_ovf_i};
  assign sif.sel = atrf_pkg::atrf_trig_type'(trig_q);

  atrf_trig_sel u_sel (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sif(sif)
  );

  // register file next state; a bus write to a result byte wins over a
  // result landing in the same cycle, since software asked last
  always_comb
  begin
    logic [15:0] p;
    p = pack(just_q, conversion_result_i);
    trig_d = trig_q;
    just_d = just_q;
    hi_d = hi_q;
    lo_d = lo_q;
    if (result_valid_i)
    begin
      hi_d = p[15:8];
      lo_d = p[7:0];
    end
    if (wr_i)
    begin
      case (addr_i)
        atrf_pkg::OFF_TRIG_CTRL:
          trig_d = wdata_i[atrf_pkg::TRIG_SEL_MSB:atrf_pkg::TRIG_SEL_LSB];
        atrf_pkg::OFF_RES_HIGH: hi_d = wdata_i;
        atrf_pkg::OFF_RES_LOW: lo_d = wdata_i;
        atrf_pkg::OFF_FORMAT: just_d = wdata_i[atrf_pkg::JUSTIFY_BIT];
        default: trig_d = trig_q;
      endcase
    end
    rdata_d = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        atrf_pkg::OFF_TRIG_CTRL:
          rdata_d = {1'b0, trig_q, 4'h0};
        atrf_pkg::OFF_RES_HIGH: rdata_d = hi_q;
        atrf_pkg::OFF_RES_LOW: rdata_d = lo_q;
        atrf_pkg::OFF_FORMAT: rdata_d = {just_q, 7'h00};
        default: rdata_d = 8'h00;
      endcase
    end
    // timer events always raise their flags, trigger use or not
    flag_d = {timer_two_period_i, timer_one_ovf_i, timer_zero_ovf_i};
  end

  // control state cleared on reset
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trig_q <= atrf_pkg::TRIG_SEL_RESET;
      just_q <= atrf_pkg::JUSTIFY_RESET;
      rdata_q <= 8'h00;
      flag_q <= 3'h0;
      start_q <= 1'b0;
    end
    else
    begin
      trig_q <= trig_d;
      just_q <= just_d;
      rdata_q <= rdata_d;
      flag_q <= flag_d;
      start_q <= sif.start;
    end
  end

  // result bytes have no reset: they keep contents through reset
  always_ff @(posedge clk_i)
  begin
    hi_q <= hi_d;
    lo_q <= lo_d;
  end

  assign rdata_o = rdata_q;
  assign start_conv_o = start_q;
  assign timer_zero_flag_o = flag_q[0];
  assign timer_one_flag_o = flag_q[1];
  assign timer_two_flag_o = flag_q[2];

  // control register: unimplemented bits, field writes and read back
  AST_CTRL_ZERO: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == atrf_pkg::OFF_TRIG_CTRL
    |=> rdata_o[7] == 1'b0 && rdata_o[3:0] == 4'h0)
    else $error("unimplemented control bits not zero");

  AST_TRIG_WRITE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == atrf_pkg::OFF_TRIG_CTRL
    |=> trig_q == $past(wdata_i[6:4]))
    else $error("trigger field not written");

  AST_CTRL_READ: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == atrf_pkg::OFF_TRIG_CTRL
    |=> rdata_o[6:4] == $past(trig_q))
    else $error("trigger field read back wrong");

  AST_SEL_HELD: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(wr_i && addr_i == atrf_pkg::OFF_TRIG_CTRL)
    |=> trig_q == $past(trig_q))
    else $error("trigger field changed without write");

  AST_JUSTIFY_WRITE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == atrf_pkg::OFF_FORMAT
    |=> just_q == $past(wdata_i[atrf_pkg::JUSTIFY_BIT]))
    else $error("justify bit not written");

  // result placement is fixed by the justify bit at capture time
  AST_LEFT_HIGH: assert property (
    @(posedge clk_i) disable iff (rst_i)
    result_valid_i && !just_q && !wr_i
    |=> hi_q == $past(conversion_result_i[9:2]))
    else $error("left high byte wrong");

  AST_LEFT_LOW: assert property (
    @(posedge clk_i) disable iff (rst_i)
    result_valid_i && !just_q && !wr_i
    |=> lo_q[7:6] == $past(conversion_result_i[1:0]))
    else $error("left low byte wrong");

  // unused bits in either format are packed as zero so software sees no stale data
  AST_LEFT_LOW_PAD: assert property (
    @(posedge clk_i) disable iff (rst_i)
    result_valid_i && !just_q && !wr_i
    |=> lo_q[5:0] == 6'h00)
    else $error("left low byte padding not zero");

  AST_RIGHT_HIGH: assert property (
    @(posedge clk_i) disable iff (rst_i)
    result_valid_i && just_q && !wr_i
    |=> hi_q[1:0] == $past(conversion_result_i[9:8]))
    else $error("right high byte wrong");

  AST_RIGHT_HIGH_PAD: assert property (
    @(posedge clk_i) disable iff (rst_i)
    result_valid_i && just_q && !wr_i
    |=> hi_q[7:2] == 6'h00)
    else $error("right high byte padding not zero");

  AST_RIGHT_LOW: assert property (
    @(posedge clk_i) disable iff (rst_i)
    result_valid_i && just_q && !wr_i
    |=> lo_q == $past(conversion_result_i[7:0]))
    else $error("right low byte wrong");

  // result bytes behave as plain storage on the bus; a write beats a
  // result landing in the same cycle
  AST_HIGH_WRITE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == atrf_pkg::OFF_RES_HIGH
    |=> hi_q == $past(wdata_i))
    else $error("high byte not written");

  AST_LOW_WRITE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_i && addr_i == atrf_pkg::OFF_RES_LOW
    |=> lo_q == $past(wdata_i))
    else $error("low byte not written");

  AST_HIGH_READ: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == atrf_pkg::OFF_RES_HIGH
    |=> rdata_o == $past(hi_q))
    else $error("high byte read back wrong");

  AST_LOW_READ: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_i && addr_i == atrf_pkg::OFF_RES_LOW
    |=> rdata_o == $past(lo_q))
    else $error("low byte read back wrong");

  AST_RESET_SEL: assert property (
    @(posedge clk_i)
    $fell(rst_i) |-> trig_q == 3'h0)
    else $error("trigger field not cleared");

  // timer events keep raising their flags whatever the selection
  AST_FLAG_ZERO: assert property (
    @(posedge clk_i) disable iff (rst_i)
    timer_zero_ovf_i |=> timer_zero_flag_o)
    else $error("timer zero flag lost");

  AST_FLAG_KEPT: assert property (
    @(posedge clk_i) disable iff (rst_i)
    timer_one_ovf_i |=> timer_one_flag_o)
    else $error("timer flag lost");

  AST_FLAG_TWO: assert property (
    @(posedge clk_i) disable iff (rst_i)
    timer_two_period_i |=> timer_two_flag_o)
    else $error("timer two flag lost");

  // start pulse: selector and top register add two cycles, so the code
  // that caused it is the one held two edges earlier
  AST_START_DELAY: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start_conv_o |-> $past(trig_q, 2) >= 3'h3)
    else $error("start under a code with no source");

  AST_START_SINGLE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start_conv_o |=> !start_conv_o)
    else $error("start longer than one cycle");

endmodule

// *** design/atrf_trig_sel.sv ***
/*
  trigger selector: picks one source by code and pulses start on its
  rising edge.
  assumes sources are already synchronous to clk_i.
*/
`timescale 1ns/1ns
module atrf_trig_sel (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // sources and selection
  atrf_src_if.sel_side sif
);

  logic lvl;
  logic prev_q;
  logic prev_d;
  logic start_q;
  logic start_d;

  // reserved codes and none select a constant low level
  always_comb
  begin
    case (sif.sel)
      atrf_pkg::TRIG_TIMER_ZERO: lvl = sif.src[0];
      atrf_pkg::TRIG_TIMER_ONE: lvl = sif.src[1];
      atrf_pkg::TRIG_TIMER_TWO: lvl = sif.src[2];
      atrf_pkg::TRIG_CMP_ONE: lvl = sif.src[3];
      atrf_pkg::TRIG_CMP_TWO: lvl = sif.src[4];
      default: lvl = 1'b0;
    endcase
    prev_d = lvl;
    start_d = lvl & ~prev_q;
  end

  // registers
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prev_q <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      prev_q <= prev_d;
      start_q <= start_d;
    end
  end

  assign sif.start = start_q;

  // start only after a low-to-high step on the selected source
  AST_EDGE_ONLY: assert property (
    @(posedge clk_i) disable iff (rst_i)
    start_q |-> !$past(prev_q) && $past(lvl))
    else $error("start without rising edge");

  // a held code that picks no source must never start anything
  AST_RSV_QUIET: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (sif.sel == atrf_pkg::TRIG_RSV1 || sif.sel == atrf_pkg::TRIG_RSV2
     || sif.sel == atrf_pkg::TRIG_NONE) ##1 $stable(sif.sel)
     |-> !start_q)
    else $error("start under reserved code");

endmodule

// *** test/tb_top.sv ***
/*
  self-checking bench for the conversion trigger and result format block.
  assumes atrf_pkg and the design files are compiled first; the bench
  drives every port itself, with no model on the far side.
*/
`timescale 1ns/1ns
module tb_top;
  // clock, reset and register port
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  // sources in order timer zero, one, two, comparator one, two
  logic [4:0] src = 5'h00;
  // one bit per flag port, so a net rather than a variable
  wire logic [2:0] flag;
  logic [9:0] res_i = 10'h000;
  logic valid_i = 1'b0;
  logic start_conv_o;
  int error_cnt = 0;
  int checks_done = 0;
  logic [7:0] start_cnt = 8'h00;
  logic [7:0] flag_cnt [3] = '{8'h00, 8'h00, 8'h00};

  atrf_top i_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .timer_zero_ovf_i(src[0]),
    .timer_one_ovf_i(src[1]),
    .timer_two_period_i(src[2]),
    .comparator_one_synced_out_i(src[3]),
    .comparator_two_synced_out_i(src[4]),
    .timer_zero_flag_o(flag[0]),
    .timer_one_flag_o(flag[1]),
    .timer_two_flag_o(flag[2]),
    .conversion_result_i(res_i),
    .result_valid_i(valid_i),
    .start_conv_o(start_conv_o)
  );

  // free-running clock, 4 ns period
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  // count every start pulse and flag pulse, so latency need not be exact
  always @(posedge clk_i)
  begin
    if (start_conv_o === 1'b1) start_cnt <= start_cnt + 8'h01;
    for (int k = 0; k < 3; k++)
      if (flag[k] === 1'b1) flag_cnt[k] <= flag_cnt[k] + 8'h01;
  end

  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic reg_rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic capture(input logic [9:0] r);
    @(posedge clk_i);
    res_i <= r;
    valid_i <= 1'b1;
    @(posedge clk_i);
    valid_i <= 1'b0;
  endtask

  // timers pulse one cycle; comparators stay high to prove edge sensing
  task automatic pulse_src(input int i);
    @(posedge clk_i);
    src[i] <= 1'b1;
    if (i > 2) repeat (6) @(posedge clk_i);
    @(posedge clk_i);
    src[i] <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // hang guard
  initial
  begin
    #200000;
    error_cnt++;
    print_verdict();
  end

  // main sequence
  initial
  begin
    logic [7:0] d;
    logic [7:0] s0;
    logic [7:0] f0;
    logic [9:0] r;
    r = 10'h2b6;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    reg_rd(atrf_pkg::OFF_TRIG_CTRL, d);
    chk("ctrl after reset", 8'h00, d);
    reg_wr(atrf_pkg::OFF_TRIG_CTRL, 8'hff);
    reg_rd(atrf_pkg::OFF_TRIG_CTRL, d);
    chk("ctrl unused bits", 8'h70, d);
    capture(r);
    reg_rd(atrf_pkg::OFF_RES_HIGH, d);
    chk("high left", r[9:2], d);
    reg_rd(atrf_pkg::OFF_RES_LOW, d);
    chk("low left top", {r[1:0], 6'h00} & 8'hc0, d & 8'hc0);
    reg_wr(atrf_pkg::OFF_FORMAT, 8'h80);
    reg_rd(atrf_pkg::OFF_FORMAT, d);
    chk("format right", 8'h80, d);
    capture(r);
    reg_rd(atrf_pkg::OFF_RES_HIGH, d);
    chk("high right", {6'h00, r[9:8]}, d & 8'h03);
    reg_rd(atrf_pkg::OFF_RES_LOW, d);
    chk("low right", r[7:0], d);
    reg_wr(atrf_pkg::OFF_RES_HIGH, 8'h5a);
    reg_wr(atrf_pkg::OFF_RES_LOW, 8'ha5);
    // second reset must clear the trigger field but keep the result bytes
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    reg_rd(atrf_pkg::OFF_RES_HIGH, d);
    chk("high kept", 8'h5a, d);
    reg_rd(atrf_pkg::OFF_RES_LOW, d);
    chk("low kept", 8'ha5, d);
    reg_rd(atrf_pkg::OFF_TRIG_CTRL, d);
    chk("ctrl cleared", 8'h00, d);
    reg_rd(atrf_pkg::OFF_FORMAT, d);
    chk("format left", 8'h00, d);
    // every code against every source; sources stay low on code change
    for (int c = 0; c < 8; c++)
    begin
      reg_wr(atrf_pkg::OFF_TRIG_CTRL, {1'b0, 3'(c), 4'h0});
      for (int i = 0; i < 5; i++)
      begin
        s0 = start_cnt;
        f0 = (i < 3) ? flag_cnt[i] : 8'h00;
        pulse_src(i);
        chk("start count", (c == i + 3) ? 8'h01 : 8'h00,
            start_cnt - s0);
        if (i < 3) chk("flag count", f0 + 8'h01, flag_cnt[i]);
      end
    end
    print_verdict();
  end
endmodule
